// ### dv/rcst_regfile_model.sv
// far-side register file and trim memory model for the register crc self-test
// assumes the block samples scan data in the same cycle and asks for trim words by level
`timescale 1ns/1ps
module rcst_regfile_model #(
  parameter logic [15:0] TRIM_BASE = 16'h3C00
) (
  input  wire logic        clk,
  input  wire logic [5:0]  scan_addr,
  output logic [15:0]      scan_data,
  input  wire logic        trim_req,
  output logic             trim_wvalid,
  output logic [15:0]      trim_wdata,
  output logic             trim_wlast
);
  logic [2:0] n;

  // stored contents: reserved slot holds junk, purge bits read as set
  function automatic logic [15:0] word_at(input logic [5:0] a);
    if (a == 6'h0D)
      return 16'hDEAD;
    if (a == 6'h0F)
      return 16'h00F3;
    return {2'h0, a, 2'h3, a} ^ 16'h5A5A;
  endfunction : word_at

  // same-cycle answer to the scanned address
  assign scan_data = word_at(scan_addr);

  // idle values at time zero
  initial
  begin
    n = 3'h0;
    trim_wvalid = 1'b0;
    trim_wlast = 1'b0;
    trim_wdata = 16'h0000;
  end

  // four trim words while reload is asked for; released data keeps changing
  always @(posedge clk)
  begin
    if (trim_req && n < 3'h4)
    begin
      trim_wvalid <= 1'b1;
      trim_wdata  <= TRIM_BASE + 16'(n);
      trim_wlast  <= (n == 3'h3);
      n           <= n + 3'h1;
    end
    else
    begin
      trim_wvalid <= 1'b0;
      trim_wlast  <= 1'b0;
      trim_wdata  <= ~trim_wdata;
      if (!trim_req)
        n <= 3'h0;
    end
  end
endmodule : rcst_regfile_model

// ### dv/rcst_top_tb.sv
// self-checking testbench for the register crc self-test block
// assumes rcst_top and the register file model beside it
`timescale 1ns/1ps
module rcst_top_tb;
  logic                clk;
  logic                rst_n;
  rcst_pkg::rcst_req_t req;
  logic                acc, rv, tr, tv, tl, md, mf, bsy, dn, fl, kd;
  logic [15:0]         rd, sd, td, tc;
  logic [5:0]          sa;
  int                  failures = 0;
  int                  total_checks = 0;
  int                  cyc = 0;
  logic [5:0]          list [22] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09,
    6'h0B, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h1B, 6'h1D, 6'h1E,
    6'h1F, 6'h3F};

  rcst_top uut (.REF_CLK(clk), .RESET_N(rst_n), .REG_REQ(req), .REG_ACCEPT(acc),
    .REG_RDATA(rd), .REG_RVALID(rv), .SCAN_ADDR(sa), .SCAN_DATA(sd), .TRIM_REQ(tr),
    .TRIM_WVALID(tv), .TRIM_WDATA(td), .TRIM_WLAST(tl), .MEM_TEST_DONE(md),
    .MEM_TEST_FAIL(mf), .SELFTEST_BUSY(bsy), .SELFTEST_DONE(dn), .SELFTEST_FAIL(fl),
    .SELFTEST_KIND(kd));
  rcst_regfile_model partner (.clk(clk), .scan_addr(sa), .scan_data(sd), .trim_req(tr),
    .trim_wvalid(tv), .trim_wdata(td), .trim_wlast(tl));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // serial crc step, msb first, own copy of the generator
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h755B : 16'h0000);
    return c;
  endfunction : crc16

  // word the scan should fold for a covered address
  function automatic logic [15:0] exp_word(input logic [5:0] a);
    if (a == 6'h0D)
      return 16'h0100;
    return partner.word_at(a) & ((a == 6'h0F) ? 16'hFFFC : 16'hFFFF);
  endfunction : exp_word

  task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, input logic [15:0] exp);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    req.rd = 1'b0;
    chk({15'h0, rv}, 16'h0001);
    chk(rd, exp);
  endtask : reg_rd

  task automatic reset_vals();
    chk({12'h0, bsy, acc, rv, dn}, 16'h0004);
    reg_rd(6'h3E, 16'h0000);
    reg_rd(6'h3F, 16'h0000);
    reg_rd(6'h30, 16'h0000);
  endtask : reset_vals

  // full run with a right or wrong expected value, traffic refused mid-run
  task automatic self_run(input logic bad);
    logic [15:0] c;
    c = 16'h0000;
    for (int k = 0; k < 21; k++)
      c = crc16(c, exp_word(list[k]));
    reg_wr(6'h3F, bad ? ~c : c);
    reg_wr(6'h0A, 16'h0001);
    for (int k = 0; k < 22; k++)
    begin
      chk({8'h0, bsy, acc, sa}, {8'h0, 1'b1, 1'b0, list[k]});
      chk({15'h0, rv}, 16'h0000);
      req = '{k == 5, k == 3, 6'h3F, 16'h1234};
      @(negedge clk);
    end
    chk({12'h0, bsy, dn, fl, kd}, {12'h0, 1'b0, 1'b1, bad, 1'b1});
    @(negedge clk);
    chk({15'h0, dn}, 16'h0000);
    reg_rd(6'h3E, bad ? crc16(c, ~c) : 16'h0000);
    reg_rd(6'h3F, bad ? ~c : c);
    reg_rd(6'h0A, 16'h0000);
    reg_rd(6'h20, 16'h0004);
    reg_rd(6'h20, 16'h0000);
  endtask : self_run

  task automatic trim_run();
    int n;
    tc = 16'h0000;
    for (int k = 0; k < 4; k++)
      tc = crc16(tc, partner.TRIM_BASE + 16'(k));
    reg_wr(6'h0A, 16'h0002);
    n = 0;
    while (tr === 1'b1 && n < 20)
    begin
      chk({13'h0, bsy, acc, dn}, 16'h0000);
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'h0005);
    reg_rd(6'h3E, tc);
  endtask : trim_run

  task automatic mem_result();
    @(negedge clk);
    md = 1'b1;
    mf = 1'b1;
    @(negedge clk);
    md = 1'b0;
    mf = 1'b0;
    chk({13'h0, dn, fl, kd}, 16'h0006);
    reg_rd(6'h3E, tc);
  endtask : mem_result

  // both trigger bits at once: the self-test wins and no reload starts
  task automatic both_bits();
    reg_wr(6'h0A, 16'h0003);
    chk({14'h0, bsy, tr}, 16'h0002);
    repeat (22) @(negedge clk);
    chk({14'h0, dn, kd}, 16'h0003);
  endtask : both_bits

  task automatic finish_test();
    $display("failures %0d total_checks %0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    md = 1'b0;
    mf = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    reset_vals();
    self_run(1'b0);
    self_run(1'b1);
    trim_run();
    mem_result();
    both_bits();
    finish_test();
  end
endmodule : rcst_top_tb

// ### hw/rcst_pkg.sv
// constants, types and the crc step shared by the register crc self-test
// assumes the surrounding register file answers covered-register reads combinationally
package rcst_pkg;

  // register offsets on the device register port
  localparam logic [5:0]  TRIG_ADDR  = 6'h0A;
  localparam logic [5:0]  RSVD_ADDR  = 6'h0D;
  localparam logic [5:0]  FIFO_ADDR  = 6'h0F;
  localparam logic [5:0]  FLAGS_ADDR = 6'h20;
  localparam logic [5:0]  CRC_ADDR   = 6'h3E;
  localparam logic [5:0]  EXP_ADDR   = 6'h3F;

  // field positions
  localparam int TRIG_SELFTEST_BIT = 0;
  localparam int TRIG_RELOAD_BIT   = 1;
  localparam int FLAG_DONE_BIT     = 0;
  localparam int FLAG_FAIL_BIT     = 1;
  localparam int FLAG_KIND_BIT     = 2;

  // reset values, masks and crc constants
  localparam logic [15:0] RSVD_RESET      = 16'h0100;
  localparam logic [15:0] EXP_RESET       = 16'h0000;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [15:0] FIFO_PURGE_MASK = 16'h0003;
  localparam logic [15:0] CRC_POLY        = 16'h755B;
  localparam logic [15:0] CRC_SEED        = 16'h0000;

  // index of the last entry in the coverage list
  localparam logic [4:0]  LAST_IDX = 5'h15;

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_TRIM} rcst_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } rcst_req_t;

  typedef struct packed {
    rcst_state_t st;
    logic [4:0]  idx;
    logic [15:0] crc;
    logic [15:0] result;
    logic [15:0] expect_val;
    logic        done;
    logic        fail;
    logic        kind;
    logic        rvalid;
    logic [15:0] rdata;
  } rcst_state_s_t;

  // covered register offsets in scan order
  function automatic logic [5:0] cover_addr(input logic [4:0] idx);
    case (idx)
      5'h00: cover_addr = 6'h01;
      5'h01: cover_addr = 6'h02;
      5'h02: cover_addr = 6'h03;
      5'h03: cover_addr = 6'h04;
      5'h04: cover_addr = 6'h05;
      5'h05: cover_addr = 6'h06;
      5'h06: cover_addr = 6'h08;
      5'h07: cover_addr = 6'h09;
      5'h08: cover_addr = 6'h0B;
      5'h09: cover_addr = 6'h0D;
      5'h0A: cover_addr = 6'h0E;
      5'h0B: cover_addr = 6'h0F;
      5'h0C: cover_addr = 6'h10;
      5'h0D: cover_addr = 6'h11;
      5'h0E: cover_addr = 6'h12;
      5'h0F: cover_addr = 6'h13;
      5'h10: cover_addr = 6'h14;
      5'h11: cover_addr = 6'h1B;
      5'h12: cover_addr = 6'h1D;
      5'h13: cover_addr = 6'h1E;
      5'h14: cover_addr = 6'h1F;
      default: cover_addr = 6'h3F;
    endcase
  endfunction : cover_addr

  // sixteen serial crc steps, msb of the word first
  function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    crc_word = c;
  endfunction : crc_word

endpackage : rcst_pkg

// ### hw/rcst_top.sv
// register crc self-test and trim-reload crc check with its own registers
// assumes an outside decoder presents register requests and a register file
// that returns the addressed covered register on SCAN_DATA in the same cycle
`timescale 1ns/1ps

// Summary of operation
// - a run feeds the covered registers through the crc in list order
// - the reserved location feeds its reset value, not its contents
// - zero final remainder means intact, non-zero means configuration error
// - result register readable, follows the crc during self-test or trim reload
// - result holds after a run until a new run or reload starts
// - one crc engine serves both tests, never at the same time
// - writing 1 starts a run; reads are refused until hardware clears the bit, so it reads low
// - during a run register writes and reads are not served
// - a run ends long before the next uart break command arrives
// - done and fail report both memory and register tests
// - kind bit: 1 register test, 0 memory test
// - kind bit sticky, cleared by reading the general flags or by a memory test result
// - both queue purge bits count as zero in the crc
// - 16-bit crc with generator 0x755B
// - generator gives distance 4 up to 2048 data bits
// - 22 covered words from 01h to 3Fh including reserved 0Dh
// - a trigger bit starts a trim reload checked by the shared crc
module rcst_top (
  input  wire logic              REF_CLK,
  input  wire logic              RESET_N,
  input  wire rcst_pkg::rcst_req_t REG_REQ,
  output logic                   REG_ACCEPT,
  output logic [15:0]            REG_RDATA,
  output logic                   REG_RVALID,
  output logic [5:0]             SCAN_ADDR,
  input  wire logic [15:0]       SCAN_DATA,
  output logic                   TRIM_REQ,
  input  wire logic              TRIM_WVALID,
  input  wire logic [15:0]       TRIM_WDATA,
  input  wire logic              TRIM_WLAST,
  input  wire logic              MEM_TEST_DONE,
  input  wire logic              MEM_TEST_FAIL,
  output logic                   SELFTEST_BUSY,
  output logic                   SELFTEST_DONE,
  output logic                   SELFTEST_FAIL,
  output logic                   SELFTEST_KIND
);

  rcst_pkg::rcst_state_s_t s_q;
  rcst_pkg::rcst_state_s_t s_d;
  logic [15:0]             scan_word;
  logic [15:0]             crc_next;
  logic [15:0]             trig_view;
  logic [15:0]             flags_view;
  logic                    wr_ok;
  logic                    rd_ok;
  logic                    start_scan;
  logic                    start_trim;
  logic                    flags_read;

  // word presented to the crc during a scan
  always_comb
  begin
    SCAN_ADDR = rcst_pkg::cover_addr(s_q.idx);
    if (SCAN_ADDR == rcst_pkg::RSVD_ADDR)
      scan_word = rcst_pkg::RSVD_RESET;
    else if (SCAN_ADDR == rcst_pkg::FIFO_ADDR)
      scan_word = SCAN_DATA & ~rcst_pkg::FIFO_PURGE_MASK;
    else if (SCAN_ADDR == rcst_pkg::EXP_ADDR)
      scan_word = s_q.expect_val;
    else
      scan_word = SCAN_DATA;
  end

  // one shared crc engine, input chosen by the running test
  always_comb
  begin
    if (s_q.st == rcst_pkg::ST_TRIM)
      crc_next = rcst_pkg::crc_word(s_q.crc, TRIM_WDATA);
    else
      crc_next = rcst_pkg::crc_word(s_q.crc, scan_word);
  end

  // access gating and register views
  always_comb
  begin
    REG_ACCEPT = (s_q.st == rcst_pkg::ST_IDLE);
    wr_ok      = REG_REQ.wr && REG_ACCEPT;
    rd_ok      = REG_REQ.rd && REG_ACCEPT;
    start_scan = wr_ok && REG_REQ.addr == rcst_pkg::TRIG_ADDR
                 && REG_REQ.wdata[rcst_pkg::TRIG_SELFTEST_BIT];
    start_trim = wr_ok && REG_REQ.addr == rcst_pkg::TRIG_ADDR
                 && REG_REQ.wdata[rcst_pkg::TRIG_RELOAD_BIT] && !start_scan;
    flags_read = rd_ok && REG_REQ.addr == rcst_pkg::FLAGS_ADDR;
    trig_view  = 16'h0000;
    trig_view[rcst_pkg::TRIG_SELFTEST_BIT] = (s_q.st == rcst_pkg::ST_SCAN);
    trig_view[rcst_pkg::TRIG_RELOAD_BIT]   = (s_q.st == rcst_pkg::ST_TRIM);
    flags_view = 16'h0000;
    flags_view[rcst_pkg::FLAG_DONE_BIT] = s_q.done;
    flags_view[rcst_pkg::FLAG_FAIL_BIT] = s_q.fail;
    flags_view[rcst_pkg::FLAG_KIND_BIT] = s_q.kind;
  end

  // next-state logic for the whole block
  always_comb
  begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.fail   = 1'b0;
    s_d.rvalid = 1'b0;
    // read answers come one cycle after the request, only when idle
    if (rd_ok)
    begin
      s_d.rvalid = 1'b1;
      case (REG_REQ.addr)
        rcst_pkg::TRIG_ADDR:  s_d.rdata = trig_view;
        rcst_pkg::FLAGS_ADDR: s_d.rdata = flags_view;
        rcst_pkg::CRC_ADDR:   s_d.rdata = s_q.result;
        rcst_pkg::EXP_ADDR:   s_d.rdata = s_q.expect_val;
        default:              s_d.rdata = 16'h0000;
      endcase
    end
    // reading the general flags clears the sticky kind bit
    if (flags_read)
      s_d.kind = 1'b0;
    if (wr_ok && REG_REQ.addr == rcst_pkg::EXP_ADDR)
      s_d.expect_val = REG_REQ.wdata;
    // memory test results share the same flags
    if (MEM_TEST_DONE)
    begin
      s_d.done = 1'b1;
      s_d.fail = MEM_TEST_FAIL;
      s_d.kind = 1'b0;
    end
    case (s_q.st)
      rcst_pkg::ST_IDLE:
      begin
        if (start_scan || start_trim)
        begin
          s_d.crc    = rcst_pkg::CRC_SEED;
          s_d.result = rcst_pkg::CRC_SEED;
          s_d.idx    = 5'h00;
          s_d.st     = start_scan ? rcst_pkg::ST_SCAN : rcst_pkg::ST_TRIM;
        end
      end
      rcst_pkg::ST_SCAN:
      begin
        s_d.crc    = crc_next;
        s_d.result = crc_next;
        s_d.idx    = s_q.idx + 5'h01;
        if (s_q.idx == rcst_pkg::LAST_IDX)
        begin
          s_d.st   = rcst_pkg::ST_IDLE;
          s_d.idx  = 5'h00;
          s_d.done = 1'b1;
          s_d.fail = (crc_next != 16'h0000);
          s_d.kind = 1'b1;
        end
      end
      rcst_pkg::ST_TRIM:
      begin
        if (TRIM_WVALID)
        begin
          s_d.crc    = crc_next;
          s_d.result = crc_next;
          if (TRIM_WLAST)
            s_d.st = rcst_pkg::ST_IDLE;
        end
      end
      default: s_d.st = rcst_pkg::ST_IDLE;
    endcase
  end

  // state register, synchronous active-low reset
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      s_q            <= '0;
      s_q.st         <= rcst_pkg::ST_IDLE;
      s_q.result     <= rcst_pkg::RESULT_RESET;
      s_q.expect_val <= rcst_pkg::EXP_RESET;
    end
    else
      s_q <= s_d;
  end

  // outputs; busy is the serial status bit the host polls
  assign REG_RDATA     = s_q.rdata;
  assign REG_RVALID    = s_q.rvalid;
  assign TRIM_REQ      = (s_q.st == rcst_pkg::ST_TRIM);
  assign SELFTEST_BUSY = (s_q.st == rcst_pkg::ST_SCAN);
  assign SELFTEST_DONE = s_q.done;
  assign SELFTEST_FAIL = s_q.fail;
  assign SELFTEST_KIND = s_q.kind;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // scan run: 22 busy cycles then done with trigger cleared
  sequence s_run;
    SELFTEST_BUSY ##22 (SELFTEST_DONE && !SELFTEST_BUSY && SELFTEST_KIND);
  endsequence

  property p_scan_order;
    SELFTEST_BUSY && s_q.idx != rcst_pkg::LAST_IDX |=> s_q.idx == $past(s_q.idx) + 5'h01;
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan order broken");

  property p_reserved_sub;
    SELFTEST_BUSY && SCAN_ADDR == rcst_pkg::RSVD_ADDR |-> scan_word == rcst_pkg::RSVD_RESET;
  endproperty
  a_reserved_sub: assert property (p_reserved_sub) else $error("reserved word wrong");

  property p_fail_verdict;
    SELFTEST_DONE && SELFTEST_KIND |-> SELFTEST_FAIL == (s_q.result != 16'h0000);
  endproperty
  a_fail_verdict: assert property (p_fail_verdict) else $error("fail verdict wrong");

  property p_result_hold;
    s_q.st == rcst_pkg::ST_IDLE ##1 s_q.st == rcst_pkg::ST_IDLE |-> $stable(s_q.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed idle");

  property p_no_overlap;
    !REG_ACCEPT && REG_REQ.wr |=> s_q.st == $past(s_q.st) || s_q.st == rcst_pkg::ST_IDLE;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("engine restarted busy");

  property p_run_length;
    start_scan |=> s_run;
  endproperty
  a_run_length: assert property (p_run_length) else $error("run length wrong");

  property p_block_read;
    REG_REQ.rd && !REG_ACCEPT |=> !REG_RVALID;
  endproperty
  a_block_read: assert property (p_block_read) else $error("read served busy");

  property p_kind_sticky;
    SELFTEST_KIND && !flags_read && !MEM_TEST_DONE |=> SELFTEST_KIND;
  endproperty
  a_kind_sticky: assert property (p_kind_sticky) else $error("kind lost");

  property p_done_once;
    SELFTEST_DONE && SELFTEST_KIND |=> !SELFTEST_DONE || $past(MEM_TEST_DONE);
  endproperty
  a_done_once: assert property (p_done_once) else $error("done not a pulse");

  // a run starts from the seed at the head of the coverage list
  property p_seed_start;
    $rose(SELFTEST_BUSY) |-> s_q.idx == 5'h00 && s_q.crc == rcst_pkg::CRC_SEED;
  endproperty
  a_seed_start: assert property (p_seed_start) else $error("run not seeded");

  property p_last_word;
    SELFTEST_BUSY && s_q.idx == rcst_pkg::LAST_IDX |-> SCAN_ADDR == rcst_pkg::EXP_ADDR;
  endproperty
  a_last_word: assert property (p_last_word) else $error("last word wrong");

  // the reserved slot folds its reset value whatever the register file says
  property p_reserved_fold;
    SELFTEST_BUSY && SCAN_ADDR == rcst_pkg::RSVD_ADDR
      |=> s_q.crc == rcst_pkg::crc_word($past(s_q.crc), rcst_pkg::RSVD_RESET);
  endproperty
  a_reserved_fold: assert property (p_reserved_fold) else $error("reserved fold wrong");

  // purge bits never reach the crc
  property p_purge_zero;
    SELFTEST_BUSY && SCAN_ADDR == rcst_pkg::FIFO_ADDR
      |-> (scan_word & rcst_pkg::FIFO_PURGE_MASK) == 16'h0000;
  endproperty
  a_purge_zero: assert property (p_purge_zero) else $error("purge bits folded");

  property p_result_follows;
    SELFTEST_BUSY || TRIM_REQ |=> s_q.result == s_q.crc;
  endproperty
  a_result_follows: assert property (p_result_follows) else $error("result lags crc");

  property p_write_blocked;
    !REG_ACCEPT |=> $stable(s_q.expect_val);
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("write served busy");

  property p_trim_alone;
    TRIM_REQ |-> !SELFTEST_BUSY && !REG_ACCEPT;
  endproperty
  a_trim_alone: assert property (p_trim_alone) else $error("engine shared at once");

  // one trim word presented while a reload runs
  sequence s_trim_word;
    TRIM_REQ && TRIM_WVALID;
  endsequence

  property p_trim_fold;
    s_trim_word |=> s_q.result == rcst_pkg::crc_word($past(s_q.crc), $past(TRIM_WDATA));
  endproperty
  a_trim_fold: assert property (p_trim_fold) else $error("trim word not folded");

  property p_trim_start;
    start_trim |=> TRIM_REQ && !SELFTEST_BUSY;
  endproperty
  a_trim_start: assert property (p_trim_start) else $error("reload did not start");

  // memory results land on the shared flags with the kind bit low
  property p_mem_report;
    MEM_TEST_DONE && !SELFTEST_BUSY
      |=> SELFTEST_DONE && SELFTEST_FAIL == $past(MEM_TEST_FAIL) && !SELFTEST_KIND;
  endproperty
  a_mem_report: assert property (p_mem_report) else $error("memory result lost");

  property p_kind_clear;
    flags_read && !MEM_TEST_DONE |=> !SELFTEST_KIND;
  endproperty
  a_kind_clear: assert property (p_kind_clear) else $error("kind not cleared");

endmodule : rcst_top
